// *** hdl/bus_cycle.sv ***
// one bus write or bus read cycle on the flash pins
module bus_cycle
  import flash_host_pkg::*;
#(
  parameter int unsigned PHASE = PHASE_CYC
)(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  // request, and read data from the data pins
  input  wire logic              start_in,
  input  wire logic              write_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [DATA_W-1:0] pins_data_in,
  // pins
  output logic                   chip_en_n_out,
  output logic                   out_en_n_out,
  output logic                   wr_en_n_out,
  output logic [ADDR_W-1:0]      address_pins_out,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic                   data_pins_oe_n_out,
  // answer
  output logic [DATA_W-1:0]      rdata_out,
  output logic                   done_out
);
  initial
  begin
    // the 8-bit counter must reach 3*PHASE-1
    if (PHASE < 2 || PHASE > 85) $error("bus_cycle: PHASE out of range");
  end

  logic [7:0] cnt;
  logic       busy;
  logic       wr;
  wire        last = busy && (cnt == 8'(3 * PHASE - 1));
  // strobe in the middle third so address is set before and held after
  wire        strobe = busy && (cnt >= 8'(PHASE)) && (cnt < 8'(2 * PHASE));

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt <= 8'h00;
      busy <= 1'b0;
      wr <= 1'b0;
      chip_en_n_out <= 1'b1;
      out_en_n_out <= 1'b1;
      wr_en_n_out <= 1'b1;
      address_pins_out <= '0;
      data_pins_out <= '0;
      data_pins_oe_n_out <= 1'b1;
      rdata_out <= '0;
      done_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_out <= last;
      if (start_in && !busy)
      begin
        busy <= 1'b1;
        cnt <= 8'h00;
        wr <= write_in;
        address_pins_out <= addr_in;
        data_pins_out <= data_in;
        data_pins_oe_n_out <= !write_in;
        chip_en_n_out <= 1'b0;
      end
      else if (busy)
      begin
        cnt <= cnt + 8'h01;
        wr_en_n_out <= !(wr && (cnt + 8'h01 >= 8'(PHASE)) && (cnt + 8'h01 < 8'(2 * PHASE)));
        out_en_n_out <= !(!wr && (cnt + 8'h01 >= 8'(PHASE)) && (cnt + 8'h01 < 8'(2 * PHASE)));
        if (strobe && !wr && cnt == 8'(2 * PHASE - 1))
          rdata_out <= pins_data_in;
        if (last)
        begin
          busy <= 1'b0;
          chip_en_n_out <= 1'b1;
          data_pins_oe_n_out <= 1'b1;
          wr_en_n_out <= 1'b1;
          out_en_n_out <= 1'b1;
        end
      end
    end
  end
endmodule

// *** hdl/flash_command_interface.sv ***
// host sequencer that issues flash command write sequences and reads
module flash_command_interface
  import flash_host_pkg::*;
#(
  parameter int unsigned PHASE       = PHASE_CYC,
  parameter int unsigned ABORT_WAIT  = ABORT_CYC,
  parameter int unsigned SUSP_WAIT   = SUSPEND_CYC,
  parameter int unsigned BLOCK_GAP   = BLOCK_WIN_CYC
)(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  // user command port
  input  wire logic              op_valid_in,
  input  wire logic [3:0]        op_code_in,
  input  wire logic [ADDR_W-1:0] op_addr_in,
  input  wire logic [DATA_W-1:0] op_data_in,
  output logic                   op_ready_out,
  output logic                   op_done_out,
  output logic [DATA_W-1:0]      op_rdata_out,
  output logic                   bypass_mode_out,
  // flash pins
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic                   data_pins_oe_n_out,
  output logic [ADDR_W-1:0]      address_pins_out,
  output logic                   chip_en_n_out,
  output logic                   out_en_n_out,
  output logic                   wr_en_n_out,
  output logic                   id_high_voltage_level_out
);
  initial
  begin
    if (ABORT_WAIT < 1 || ABORT_WAIT >= (1 << WAIT_W)) $error("ABORT_WAIT out of range");
    if (SUSP_WAIT < 1 || SUSP_WAIT >= (1 << WAIT_W)) $error("SUSP_WAIT out of range");
    if (BLOCK_GAP < 2 || BLOCK_GAP >= (1 << WAIT_W)) $error("BLOCK_GAP out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_BUS  = 3'b011,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b110
  } state_t;

  state_t              state;
  op_t                 op;
  logic [2:0]          step;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [WAIT_W-1:0]   wait_cnt;
  logic                bypass;
  logic                id_hv;
  logic                cyc_start;
  logic                cyc_write;
  logic [ADDR_W-1:0]   cyc_addr;
  logic [DATA_W-1:0]   cyc_data;
  wire  [DATA_W-1:0]   cyc_rdata;
  wire                 cyc_done;

  // unlock words use only the low 11 address bits; upper bits stay zero
  wire [ADDR_W-1:0] ua1 = UNLOCK1_ADDR & 18'h007FF;
  wire [ADDR_W-1:0] ua2 = UNLOCK2_ADDR & 18'h007FF;
  wire [2:0] n_steps =
    (op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME || op == OP_BLOCK_ADD ||
     op == OP_READ || op == OP_ID_READ) ? 3'd1 :
    (op == OP_BYP_PROG || op == OP_BYP_EXIT) ? 3'd2 :
    (op == OP_RESET3 || op == OP_AUTOSEL || op == OP_BYPASS) ? 3'd3 :
    (op == OP_PROGRAM) ? 3'd4 : 3'd6;
  wire is_read = (op == OP_READ) || (op == OP_ID_READ);
  wire unlock_step = (step == 3'd0) || (step == 3'd3);
  wire pair_step = (step == 3'd1) || (step == 3'd4);
  wire multi = (n_steps >= 3'd3);
  // in bypass mode only bypass program, bypass exit, the single reset and reads are sent
  wire op_legal = !bypass ||
    (op == OP_BYP_PROG) || (op == OP_BYP_EXIT) || (op == OP_RESET) || is_read;
  wire [DATA_W-1:0] third_data =
    (op == OP_RESET3) ? CMD_RESET : (op == OP_AUTOSEL) ? CMD_AUTOSEL :
    (op == OP_PROGRAM) ? CMD_PROGRAM : (op == OP_BYPASS) ? CMD_BYPASS : CMD_ERASE;
  wire [DATA_W-1:0] single_data =
    (op == OP_RESET) ? CMD_RESET : (op == OP_SUSPEND) ? CMD_SUSPEND :
    (op == OP_RESUME) ? CMD_RESUME : CMD_BLOCK_ER;

  // word of the current step; unlock pair then command byte then payload
  logic [ADDR_W-1:0] step_addr;
  logic [DATA_W-1:0] step_data;
  always_comb
  begin
    step_addr = addr;
    step_data = wdata;
    if (!multi && n_steps == 3'd1)
    begin
      step_data = single_data;
    end
    else if (op == OP_BYP_PROG)
    begin
      step_data = (step == 3'd0) ? CMD_PROGRAM : wdata;
    end
    else if (op == OP_BYP_EXIT)
    begin
      step_data = (step == 3'd0) ? CMD_AUTOSEL : CMD_BYP_EXIT;
    end
    else if (unlock_step && step < n_steps - 3'd1)
    begin
      step_addr = ua1;
      step_data = UNLOCK1_DATA;
    end
    else if (pair_step)
    begin
      step_addr = ua2;
      step_data = UNLOCK2_DATA;
    end
    else if (step == 3'd2)
    begin
      step_addr = ua1;
      step_data = third_data;
    end
    else if (op == OP_CHIP_ER)
    begin
      step_addr = ua1;
      step_data = CMD_CHIP_ER;
    end
    else if (op == OP_BLOCK_ER)
    begin
      step_data = CMD_BLOCK_ER;
    end
  end

  // reads of array, status or ids; id reads raise id_high_voltage_level_out for the cycle
  wire [ADDR_W-1:0] rd_addr = addr;
  wire [WAIT_W-1:0] post_wait =
    (op == OP_RESET) ? WAIT_W'(ABORT_WAIT) :
    (op == OP_SUSPEND) ? WAIT_W'(SUSP_WAIT) :
    (op == OP_BLOCK_ER || op == OP_BLOCK_ADD) ? WAIT_W'(BLOCK_GAP - 1) :
    WAIT_W'(0);
  wire last_step = (step == n_steps - 3'd1);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      op <= OP_READ;
      step <= 3'd0;
      addr <= '0;
      wdata <= '0;
      wait_cnt <= '0;
      bypass <= 1'b0;
      id_hv <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= '0;
      cyc_data <= '0;
      op_ready_out <= 1'b0;
      op_done_out <= 1'b0;
      op_rdata_out <= '0;
      bypass_mode_out <= 1'b0;
      id_high_voltage_level_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cyc_start <= 1'b0;
      op_done_out <= 1'b0;
      bypass_mode_out <= bypass;
      id_high_voltage_level_out <= id_hv;
      case (state)
        ST_IDLE:
        begin
          op_ready_out <= 1'b1;
          if (op_valid_in && op_ready_out)
          begin
            op <= op_t'(op_code_in);
            addr <= op_addr_in;
            wdata <= op_data_in;
            step <= 3'd0;
            op_ready_out <= 1'b0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          // unknown codes are dropped with no pin activity
          if (!op_legal || op > OP_ID_READ)
          begin
            state <= ST_DONE;
          end
          else
          begin
            cyc_start <= 1'b1;
            cyc_write <= !is_read;
            cyc_addr <= is_read ? rd_addr : step_addr;
            cyc_data <= step_data;
            id_hv <= (op == OP_ID_READ);
            state <= ST_BUS;
          end
        end
        ST_BUS:
        begin
          if (cyc_done)
          begin
            id_hv <= 1'b0;
            if (is_read)
              op_rdata_out <= cyc_rdata;
            if (last_step || is_read)
            begin
              wait_cnt <= post_wait;
              state <= ST_WAIT;
              if (op == OP_BYPASS)
                bypass <= 1'b1;
              else if (op == OP_BYP_EXIT)
                bypass <= 1'b0;  // reset keeps bypass
            end
            else
            begin
              step <= step + 3'd1;
              state <= ST_LOAD;
            end
          end
        end
        ST_WAIT:
        begin
          if (wait_cnt == '0)
            state <= ST_DONE;
          else
            wait_cnt <= wait_cnt - WAIT_W'(1);
        end
        default:
        begin
          op_done_out <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  bus_cycle #(
    .PHASE (PHASE)
  ) u_cycle (
    .ref_clk_in         (ref_clk_in),
    .rst_in             (rst_in),
    .clk_en_in          (clk_en_in),
    .start_in           (cyc_start),
    .write_in           (cyc_write),
    .addr_in            (cyc_addr),
    .data_in            (cyc_data),
    .pins_data_in       (data_pins_in),
    .chip_en_n_out      (chip_en_n_out),
    .out_en_n_out       (out_en_n_out),
    .wr_en_n_out        (wr_en_n_out),
    .address_pins_out   (address_pins_out),
    .data_pins_out      (data_pins_out),
    .data_pins_oe_n_out (data_pins_oe_n_out),
    .rdata_out          (cyc_rdata),
    .done_out           (cyc_done)
  );
endmodule

// *** pkg/flash_host_pkg.sv ***
// constants for the flash command host controller
package flash_host_pkg;
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CMD_ADDR_W    = 11;
  localparam logic [17:0] UNLOCK1_ADDR  = 18'h00555;
  localparam logic [17:0] UNLOCK2_ADDR  = 18'h002AA;
  localparam logic [7:0]  UNLOCK1_DATA  = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_BYPASS    = 8'h20;
  localparam logic [7:0]  CMD_BYP_EXIT  = 8'h00;
  localparam logic [7:0]  CMD_ERASE     = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ER   = 8'h10;
  localparam logic [7:0]  CMD_BLOCK_ER  = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0]  CMD_RESUME    = 8'h30;
  localparam logic [7:0]  PROT_YES      = 8'h01;
  localparam logic [17:0] ID_MAKER_ADDR = 18'h00000;
  localparam logic [17:0] ID_PART_ADDR  = 18'h00001;
  localparam logic [17:0] ID_PROT_ADDR  = 18'h00002;
  localparam int unsigned BLOCK_LSB     = 13;
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned ABORT_US      = 10;
  localparam int unsigned SUSPEND_US    = 15;
  localparam int unsigned BLOCK_WIN_US  = 50;
  localparam int unsigned ABORT_CYC     = ABORT_US * CLK_MHZ;
  localparam int unsigned SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
  localparam int unsigned BLOCK_WIN_CYC = BLOCK_WIN_US * CLK_MHZ;
  localparam int unsigned PHASE_CYC     = 8;
  localparam int unsigned WAIT_W        = 16;
  typedef enum logic [3:0] {
    OP_RESET     = 4'h0,
    OP_RESET3    = 4'h1,
    OP_AUTOSEL   = 4'h2,
    OP_PROGRAM   = 4'h3,
    OP_BYPASS    = 4'h4,
    OP_BYP_PROG  = 4'h5,
    OP_BYP_EXIT  = 4'h6,
    OP_CHIP_ER   = 4'h7,
    OP_BLOCK_ER  = 4'h8,
    OP_BLOCK_ADD = 4'h9,
    OP_SUSPEND   = 4'hA,
    OP_RESUME    = 4'hB,
    OP_READ      = 4'hC,
    OP_ID_READ   = 4'hD
  } op_t;
endpackage

// *** tb/flash_command_interface_sva.sv ***
// pin protocol assertions for the flash host controller
module flash_command_interface_sva
(
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        op_valid_in,
  input wire logic        op_ready_out,
  input wire logic        op_done_out,
  input wire logic [7:0]  data_pins_out,
  input wire logic        data_pins_oe_n_out,
  input wire logic [17:0] address_pins_out,
  input wire logic        chip_en_n_out,
  input wire logic        out_en_n_out,
  input wire logic        wr_en_n_out,
  input wire logic        id_high_voltage_level_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_write;
    !chip_en_n_out && out_en_n_out && !data_pins_oe_n_out;
  endsequence
  sequence s_unlock2;
    $fell(wr_en_n_out) && data_pins_out == 8'h55 && address_pins_out[10:0] == 11'h2AA;
  endsequence
  property p_write_cycle;
    $fell(wr_en_n_out) |-> s_write ##[1:40] (wr_en_n_out && !chip_en_n_out);
  endproperty
  property p_write_hold;
    !wr_en_n_out && $past(!wr_en_n_out) |-> $stable(address_pins_out) && $stable(data_pins_out);
  endproperty
  property p_read_float;
    !out_en_n_out |-> data_pins_oe_n_out && wr_en_n_out && !chip_en_n_out;
  endproperty
  property p_hv_read;
    id_high_voltage_level_out |-> wr_en_n_out;
  endproperty
  property p_idle_quiet;
    op_ready_out |-> chip_en_n_out && data_pins_oe_n_out;
  endproperty
  property p_take;
    op_valid_in && op_ready_out |=> !op_ready_out ##[0:300] op_done_out;
  endproperty
  property p_done_pulse;
    op_done_out |=> !op_done_out ##[0:1] op_ready_out;
  endproperty
  property p_unlock_pair;
    $fell(wr_en_n_out) && data_pins_out == 8'hAA && address_pins_out[10:0] == 11'h555
      |-> ##[1:40] s_unlock2;
  endproperty
  a_write_cycle: assert property (p_write_cycle) else $error("bad write cycle");
  a_write_hold: assert property (p_write_hold) else $error("write bus moved");
  a_read_float: assert property (p_read_float) else $error("bad read cycle");
  a_hv_read: assert property (p_hv_read) else $error("id voltage on write");
  a_idle_quiet: assert property (p_idle_quiet) else $error("pins busy in idle");
  a_take: assert property (p_take) else $error("op not completed");
  a_done_pulse: assert property (p_done_pulse) else $error("bad done pulse");
  a_unlock_pair: assert property (p_unlock_pair) else $error("unlock pair broken");
endmodule
bind flash_command_interface flash_command_interface_sva chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
  .op_ready_out(op_ready_out), .op_done_out(op_done_out), .data_pins_out(data_pins_out),
  .data_pins_oe_n_out(data_pins_oe_n_out), .address_pins_out(address_pins_out),
  .chip_en_n_out(chip_en_n_out), .out_en_n_out(out_en_n_out), .wr_en_n_out(wr_en_n_out),
  .id_high_voltage_level_out(id_high_voltage_level_out));

// *** tb/flash_model.sv ***
// behavioural flash device answering the host pins
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5E, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'h6B, // arbitrary value
  parameter logic [4:0] PROT_BLK = 5'h03
)(
  // strobes
  input  wire logic              chip_en_n_in,
  input  wire logic              out_en_n_in,
  input  wire logic              wr_en_n_in,
  input  wire logic              id_hv_in,
  // bus
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] host_data_in,
  input  wire logic              host_oe_n_in,
  output logic      [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [logic [17:0]];
  logic [25:0] wlog [$];
  logic [1:0]  step = 2'h0;
  logic        asel = 1'b0, byp = 1'b0, prog = 1'b0, ex = 1'b0, er = 1'b0;
  logic [7:0]  rd;
  logic [7:0]  last = 8'h00;
  wire  [10:0] ca = addr_in[10:0];
  wire  [7:0]  d = host_data_in;
  function automatic logic [7:0] rd_arr(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // data latched on the rising write strobe
  always @(posedge wr_en_n_in)
    if (!chip_en_n_in)
    begin
      wlog.push_back({addr_in, d});
      if (prog)
      begin
        if (addr_in[17:13] != PROT_BLK)
          mem[addr_in] = rd_arr(addr_in) & d;
        prog = 1'b0;
      end
      else if (byp)
      begin
        prog = (d == 8'hA0);
        byp  = !(ex && d == 8'h00);
        ex   = (d == 8'h90);
      end
      else if (step == 2'h0 && ca == 11'h555 && d == 8'hAA)
        step = 2'h1;
      else if (step == 2'h1 && ca == 11'h2AA && d == 8'h55)
        step = 2'h2;
      else
      begin
        asel = step == 2'h2 && ca == 11'h555 && d == 8'h90;
        prog = step == 2'h2 && ca == 11'h555 && d == 8'hA0;
        byp  = step == 2'h2 && ca == 11'h555 && d == 8'h20;
        if (er && step == 2'h2 && d == 8'h10)
          mem.delete();
        er   = step == 2'h2 && d == 8'h80;
        ex   = 1'b0;
        step = 2'h0;
      end
    end
  always_comb
    if (id_hv_in || (asel && !addr_in[1]))
      rd = addr_in[0] ? PART_ID : MAKER_ID;
    else if (asel)
      rd = {7'h00, addr_in[17:13] == PROT_BLK};
    else
      rd = rd_arr(addr_in);
  // released bus shows the inverse of the last byte, never a stale copy
  always @(posedge out_en_n_in)
    last = rd;
  assign dq_out = !host_oe_n_in ? host_data_in
                : (!chip_en_n_in && !out_en_n_in && wr_en_n_in) ? rd : ~last;
endmodule

// *** tb/test_flash_command_interface.sv ***
// self-checking bench for the flash command host controller
module test_flash_command_interface
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] TA    = 18'h12345;
  localparam logic [7:0]  MAKER = 8'h5E;
  localparam logic [7:0]  PART  = 8'h6B;
  logic        ref_clk_in, rst_in, vld, rdy, done, byp, dq_oe_n, ce_n, oe_n, we_n, hv;
  logic        cen;
  logic [3:0]  code;
  logic [17:0] addr, ap;
  logic [7:0]  wdat, rdat, dq_in, dq;
  int          n_mismatch, cmp_count;
  flash_command_interface #(.PHASE(2), .ABORT_WAIT(4), .SUSP_WAIT(6), .BLOCK_GAP(8)) uut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(cen), .op_valid_in(vld),
    .op_code_in(code), .op_addr_in(addr), .op_data_in(wdat), .op_ready_out(rdy),
    .op_done_out(done), .op_rdata_out(rdat), .bypass_mode_out(byp), .data_pins_in(dq_in),
    .data_pins_out(dq), .data_pins_oe_n_out(dq_oe_n), .address_pins_out(ap),
    .chip_en_n_out(ce_n), .out_en_n_out(oe_n), .wr_en_n_out(we_n),
    .id_high_voltage_level_out(hv));
  flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (
    .chip_en_n_in(ce_n), .out_en_n_in(oe_n), .wr_en_n_in(we_n), .id_hv_in(hv),
    .addr_in(ap), .host_data_in(dq), .host_oe_n_in(dq_oe_n), .dq_out(dq_in));
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // which: 0 waits for ready, 1 for done; sampled after the edge settles
  task automatic wait_hi(input bit which);
    int n;
    n = 0;
    while ((which ? done : rdy) !== 1'b1)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
      if (n > 400)
      begin
        n_mismatch++;
        summarize();
      end
    end
  endtask
  task automatic do_op(input op_t c, input logic [17:0] a, input logic [7:0] d);
    wait_hi(0);
    dev.wlog.delete();
    @(posedge ref_clk_in);
    vld  <= 1'b1;
    code <= c;
    addr <= a;
    wdat <= d;
    @(posedge ref_clk_in);
    vld <= 1'b0;
    wait_hi(1);
  endtask
  function automatic logic [19:0] w(input logic c, input logic [10:0] a, input logic [7:0] d);
    return {c, a, d};
  endfunction
  task automatic t_sequences();
    logic [19:0] u [$];
    logic [19:0] e [$];
    u = '{w(1, 11'h555, 8'hAA), w(1, 11'h2AA, 8'h55)};
    for (int i = 0; i < 12; i++)
    begin
      do_op(op_t'(i), TA, 8'h3C);
      case (op_t'(i))
        OP_RESET:     e = {w(0, 11'h000, 8'hF0)};
        OP_RESET3:    e = {u, w(0, 11'h000, 8'hF0)};
        OP_AUTOSEL:   e = {u, w(1, 11'h555, 8'h90)};
        OP_PROGRAM:   e = {u, w(1, 11'h555, 8'hA0), w(1, TA[10:0], 8'h3C)};
        OP_BYPASS:    e = {u, w(1, 11'h555, 8'h20)};
        OP_BYP_PROG:  e = {w(0, 11'h000, 8'hA0), w(1, TA[10:0], 8'h3C)};
        OP_BYP_EXIT:  e = {w(0, 11'h000, 8'h90), w(0, 11'h000, 8'h00)};
        OP_CHIP_ER:   e = {u, w(1, 11'h555, 8'h80), u, w(1, 11'h555, 8'h10)};
        OP_BLOCK_ER:  e = {u, w(1, 11'h555, 8'h80), u, w(1, TA[10:0], 8'h30)};
        OP_SUSPEND:   e = {w(0, 11'h000, 8'hB0)};
        default:      e = {w(1, TA[10:0], 8'h30)};
      endcase
      check(18'(dev.wlog.size()), 18'(e.size()));
      foreach (e[k])
        if (k < dev.wlog.size())
        begin
          check(18'(dev.wlog[k][7:0]), 18'(e[k][7:0]));
          if (e[k][19])
            check(18'(dev.wlog[k][18:8]), 18'(e[k][18:8]));
        end
      check(18'(byp), 18'(i == 4 || i == 5));
    end
  endtask
  task automatic t_program();
    do_op(OP_CHIP_ER, TA, 8'h00);
    do_op(OP_PROGRAM, TA, 8'h5A);
    do_op(OP_PROGRAM, TA, 8'h0F);
    do_op(OP_READ, TA, 8'h00);
    check(18'(rdat), 18'h0A);
    do_op(OP_PROGRAM, 18'h06000, 8'h12);
    do_op(OP_READ, 18'h06000, 8'h00);
    check(18'(rdat), 18'hFF);
  endtask
  // clock enable held low mid-program must freeze the pins
  task automatic t_freeze();
    logic        ce_hold;
    logic [17:0] ap_hold;
    do_op(OP_CHIP_ER, TA, 8'h00);
    fork
      do_op(OP_PROGRAM, TA, 8'h81);
      begin
        repeat (14) @(posedge ref_clk_in);
        cen <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        ce_hold = ce_n;
        ap_hold = ap;
        repeat (20) @(posedge ref_clk_in);
        #1;
        check(18'(ce_n), 18'(ce_hold));
        check(ap, ap_hold);
        @(posedge ref_clk_in);
        cen <= 1'b1;
      end
    join
    do_op(OP_READ, TA, 8'h00);
    check(18'(rdat), 18'h81);
  endtask
  task automatic t_ident();
    logic [17:0] ra [4];
    logic [7:0]  rv [4];
    ra = '{18'h3E000, 18'h3E001, 18'h06002, 18'h08002};
    rv = '{MAKER, PART, 8'h01, 8'h00};
    do_op(OP_ID_READ, 18'h3E001, 8'h00);
    check(18'(rdat), 18'(PART));
    do_op(OP_AUTOSEL, TA, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      do_op(OP_READ, ra[i], 8'h00);
      check(18'(rdat), 18'(rv[i]));
    end
    do_op(OP_RESET, TA, 8'h00);
    do_op(OP_READ, 18'h3E000, 8'h00);
    check(18'(rdat), 18'hFF);
  endtask
  task automatic t_bypass();
    do_op(OP_BYPASS, TA, 8'h00);
    do_op(OP_AUTOSEL, TA, 8'h00);
    check(18'(dev.wlog.size()), 18'h0);
    do_op(OP_BYP_PROG, 18'h20000, 8'hC3);
    do_op(OP_READ, 18'h20000, 8'h00);
    check(18'(rdat), 18'hC3);
    do_op(OP_BYP_EXIT, TA, 8'h00);
    check(18'(byp), 18'h0);
  endtask
  initial
  begin
    ref_clk_in = 1'b0;
    forever
      #4 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    {vld, code, addr, wdat, n_mismatch, cmp_count} = '0;
    cen = 1'b1;
    rst_in = 1'b1;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_sequences();
    t_program();
    t_freeze();
    t_ident();
    t_bypass();
    summarize();
  end
endmodule
